// file: loop_responder_pkg.sv
// Shared types and constants for the loop message responder.
// Assumes one 125 MHz clock domain; every user of this package names it explicitly.
`default_nettype none

package loop_responder_pkg;

	typedef enum logic [3:0] {
		MSG_DATA_BYTE     = 4'h0,
		MSG_ACCESSORY_ID  = 4'h1,
		MSG_DEVICE_ID     = 4'h2,
		MSG_STATUS        = 4'h3,
		MSG_SYSTEM_STATUS = 4'h4,
		MSG_SELECTED_CLR  = 4'h5,
		MSG_LOOP_CLR      = 4'h6,
		MSG_DEP_LISTENER  = 4'h7,
		MSG_DEP_TALKER    = 4'h8,
		MSG_LISTEN_ADDR   = 4'h9,
		MSG_GO_LOCAL      = 4'hA,
		MSG_REMOTE_ENABLE = 4'hB,
		MSG_REMOTE_DIS    = 4'hC
	} msg_kind_e;

	typedef struct packed {
		msg_kind_e   kind;
		logic [7:0]  data;
	} msg_s;

	typedef struct packed {
		logic        eot;
		logic [7:0]  data;
	} reply_s;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'h0,
		ST_ACCESSORY = 3'h1,
		ST_IDENT     = 3'h2,
		ST_STATUS    = 3'h3,
		ST_DRAIN     = 3'h4
	} reply_state_e;

	localparam int unsigned DATA_WIDTH  = 8;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam logic [4:0]  ADDR_UNLISTEN = 5'h1F;
	// Accessory class code: value arbitrary
	localparam logic [7:0]  ACCESSORY_CLASS = 8'h5A;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [7:0]  CHAR_RESET = 8'h0D;
	localparam logic [7:0]  CHAR_CR = 8'h0D;
	localparam logic [7:0]  CHAR_LF = 8'h0A;
	localparam logic [7:0]  EOT_FILL = 8'h00;
	// Model string "RSLINK" then CR LF: value arbitrary
	localparam int unsigned ID_LEN = 8;
	localparam logic [3:0]  ID_LAST = 4'h7;
	localparam logic [7:0]  ID_TEXT [0:ID_LEN-1] = '{8'h52, 8'h53, 8'h4C, 8'h49, 8'h4E, 8'h4B, CHAR_CR, CHAR_LF};
	localparam logic [3:0]  STATUS_LAST_FULL = 4'h3;
	localparam logic [3:0]  STATUS_LAST_SYS = 4'h0;

endpackage : loop_responder_pkg

`default_nettype wire

// file: loop_byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes writer and reader share one clock; flush wins over a same-cycle push.
`default_nettype none

module loop_byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                       i_clock,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_flush,
	input  wire logic                       i_in_valid,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_in_ready,
	output logic                            o_out_valid,
	output logic [WIDTH-1:0]                o_out_data,
	input  wire logic                       i_out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	wire              push = i_in_valid & o_in_ready;
	wire              pop = o_out_valid & i_out_ready;

	assign o_in_ready  = (count != CW'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = store[rd_ptr];
	assign o_count     = count;

	always_ff @(posedge i_clock)
	begin
		if (push)
			store[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (i_flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= AW'(wr_ptr + 1'b1);
			if (pop)
				rd_ptr <= AW'(rd_ptr + 1'b1);
			count <= CW'(count + CW'(push) - CW'(pop));
		end
	end

endmodule : loop_byte_fifo

`default_nettype wire

// file: loop_message_responder.sv
// Message-response logic of a serial-loop peripheral bridging to a serial port.
// Assumes decoded loop messages and received bytes arrive on i_clock; talker status is given from outside.
// Overview of operation
// - Accessory request returns one fixed class byte
// - Any clear empties the FIFO, resets control and character registers
// - Listener command acts only while listener
// - Talker command acts only while talker
// - Matching address makes listener; 31 unlistens
// - Identification sends model string, CR, LF
// - Talking data ends with end-of-transmission
// - Status reply starts with system status
// - Go-local keeps remote enable set
// - Remote disable clears remote enable
// - Remote mode data becomes configuration
`default_nettype none

module loop_message_responder (
	input  wire logic                      i_clock,
	input  wire logic                      i_arst_n,
	input  wire logic                      i_msg_valid,
	input  wire loop_responder_pkg::msg_s  i_msg,
	output logic                           o_msg_ready,
	input  wire logic [4:0]                i_own_addr,
	input  wire logic                      i_talker,
	input  wire logic                      i_rx_valid,
	input  wire logic [7:0]                i_rx_data,
	output logic                           o_rx_ready,
	output logic                           o_reply_valid,
	output loop_responder_pkg::reply_s     o_reply,
	input  wire logic                      i_reply_ready,
	output logic                           o_ext_valid,
	output logic [7:0]                     o_ext_data,
	output logic                           o_listener,
	output logic                           o_remote,
	output logic                           o_remote_enable,
	output logic [7:0]                     o_ctrl,
	output logic [7:0]                     o_char
);

	loop_responder_pkg::reply_state_e state;
	logic [3:0]  idx;
	logic [3:0]  status_last;
	logic [4:0]  fifo_count;
	logic        fifo_valid;
	logic [7:0]  fifo_data;

	// Message decode
	wire take_msg = i_msg_valid & o_msg_ready;
	wire [7:0] msg_data = i_msg.data;
	wire is_data = take_msg & (i_msg.kind == loop_responder_pkg::MSG_DATA_BYTE);
	wire is_aid = take_msg & (i_msg.kind == loop_responder_pkg::MSG_ACCESSORY_ID);
	wire is_id = take_msg & (i_msg.kind == loop_responder_pkg::MSG_DEVICE_ID);
	wire is_stat = take_msg & (i_msg.kind == loop_responder_pkg::MSG_STATUS);
	wire is_sys = take_msg & (i_msg.kind == loop_responder_pkg::MSG_SYSTEM_STATUS);
	wire is_clear = take_msg & ((i_msg.kind == loop_responder_pkg::MSG_SELECTED_CLR)
		| (i_msg.kind == loop_responder_pkg::MSG_LOOP_CLR));
	wire is_ddl = take_msg & (i_msg.kind == loop_responder_pkg::MSG_DEP_LISTENER);
	wire is_ddt = take_msg & (i_msg.kind == loop_responder_pkg::MSG_DEP_TALKER);
	wire is_lad = take_msg & (i_msg.kind == loop_responder_pkg::MSG_LISTEN_ADDR);
	wire is_gtl = take_msg & (i_msg.kind == loop_responder_pkg::MSG_GO_LOCAL);
	wire is_ren = take_msg & (i_msg.kind == loop_responder_pkg::MSG_REMOTE_ENABLE);
	wire is_rdis = take_msg & (i_msg.kind == loop_responder_pkg::MSG_REMOTE_DIS);

	wire lad_unl = is_lad & (msg_data[4:0] == loop_responder_pkg::ADDR_UNLISTEN);
	wire lad_hit = is_lad & ~lad_unl & (msg_data[4:0] == i_own_addr);
	wire ddl_exec = is_ddl & o_listener;
	wire ddt_exec = is_ddt & i_talker;
	wire data_remote = is_data & o_listener & o_remote;
	wire data_local = is_data & o_listener & ~o_remote;

	// New messages wait while a reply is being produced, so replies never interleave
	assign o_msg_ready = (state == loop_responder_pkg::ST_IDLE);

	// Reply generation
	wire [7:0] sys_status = {o_listener, i_talker, o_remote, o_remote_enable,
		~fifo_valid, ~o_rx_ready, 2'b00};
	wire [7:0] stat_byte = (idx == 4'h0) ? sys_status :
		(idx == 4'h1) ? o_ctrl :
		(idx == 4'h2) ? o_char : {3'b000, fifo_count};
	wire in_acc = (state == loop_responder_pkg::ST_ACCESSORY);
	wire in_id = (state == loop_responder_pkg::ST_IDENT);
	wire in_stat = (state == loop_responder_pkg::ST_STATUS);
	wire in_drain = (state == loop_responder_pkg::ST_DRAIN);
	wire drain_eot = in_drain & ~fifo_valid;
	wire [7:0] gen_byte = in_acc ? loop_responder_pkg::ACCESSORY_CLASS :
		in_id ? loop_responder_pkg::ID_TEXT[idx[2:0]] :
		in_stat ? stat_byte :
		drain_eot ? loop_responder_pkg::EOT_FILL : fifo_data;
	wire gen_last = in_acc | drain_eot
		| (in_id & (idx == loop_responder_pkg::ID_LAST))
		| (in_stat & (idx == status_last));
	wire gen_valid = ~o_msg_ready;
	wire take = gen_valid & (~o_reply_valid | i_reply_ready);
	wire fifo_pop = take & in_drain & fifo_valid;

	loop_byte_fifo #(
		.WIDTH (loop_responder_pkg::DATA_WIDTH),
		.DEPTH (loop_responder_pkg::FIFO_DEPTH)
	) rx_fifo (
		.i_clock     (i_clock),
		.i_arst_n    (i_arst_n),
		.i_flush     (is_clear),
		.i_in_valid  (i_rx_valid),
		.i_in_data   (i_rx_data),
		.o_in_ready  (o_rx_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (fifo_pop),
		.o_count     (fifo_count)
	);

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state <= loop_responder_pkg::ST_IDLE;
		else if (take & gen_last)
			state <= loop_responder_pkg::ST_IDLE;
		else if (is_aid)
			state <= loop_responder_pkg::ST_ACCESSORY;
		else if (is_id)
			state <= loop_responder_pkg::ST_IDENT;
		else if (is_stat | is_sys)
			state <= loop_responder_pkg::ST_STATUS;
		else if (ddt_exec)
			state <= loop_responder_pkg::ST_DRAIN;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			idx         <= 4'h0;
			status_last <= loop_responder_pkg::STATUS_LAST_FULL;
		end
		else
		begin
			if (take & gen_last)
				idx <= 4'h0;
			else if (take & ~in_drain)
				idx <= 4'(idx + 4'h1);
			if (is_stat | is_sys)
				status_last <= is_sys ? loop_responder_pkg::STATUS_LAST_SYS
					: loop_responder_pkg::STATUS_LAST_FULL;
		end
	end

	// Output register holds a byte until the controller side takes it
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_reply_valid <= 1'b0;
			o_reply       <= '0;
		end
		else if (take)
		begin
			o_reply_valid <= 1'b1;
			o_reply       <= '{eot: drain_eot, data: gen_byte};
		end
		else if (i_reply_ready)
			o_reply_valid <= 1'b0;
	end

	// Addressing and mode
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_listener      <= 1'b0;
			o_remote        <= 1'b0;
			o_remote_enable <= 1'b0;
		end
		else
		begin
			if (lad_unl)
				o_listener <= 1'b0;
			else if (lad_hit)
				o_listener <= 1'b1;
			if (is_rdis)
				o_remote_enable <= 1'b0;
			else if (is_ren)
				o_remote_enable <= 1'b1;
			// Go-local leaves the enable alone so the next addressing returns to remote
			if (is_gtl | is_rdis)
				o_remote <= 1'b0;
			else if ((lad_hit & o_remote_enable) | (is_ren & o_listener))
				o_remote <= 1'b1;
		end
	end

	// Control and character registers, and the path to the external device
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_ctrl      <= loop_responder_pkg::CTRL_RESET;
			o_char      <= loop_responder_pkg::CHAR_RESET;
			o_ext_valid <= 1'b0;
			o_ext_data  <= 8'h00;
		end
		else
		begin
			if (is_clear)
			begin
				o_ctrl <= loop_responder_pkg::CTRL_RESET;
				o_char <= loop_responder_pkg::CHAR_RESET;
			end
			else
			begin
				if (ddl_exec)
					o_ctrl <= msg_data;
				if (data_remote)
					o_char <= msg_data;
			end
			o_ext_valid <= data_local;
			if (data_local)
				o_ext_data <= msg_data;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	listen_hit_a: assert property (lad_hit |=> o_listener) else $error("listener not set");
	unlisten_a: assert property (lad_unl |=> !o_listener) else $error("listener not cleared");
	clear_regs_a: assert property (is_clear |=> o_ctrl == loop_responder_pkg::CTRL_RESET
		&& o_char == loop_responder_pkg::CHAR_RESET && fifo_count == 5'h00) else $error("clear incomplete");
	ddl_gate_a: assert property (is_ddl && !o_listener |=> $stable(o_ctrl)) else $error("ddl while not listener");
	ddt_gate_a: assert property (is_ddt && !i_talker |=> o_msg_ready) else $error("ddt while not talker");
	accessory_byte_a: assert property (take && in_acc |=> o_reply_valid
		&& o_reply.data == loop_responder_pkg::ACCESSORY_CLASS ##0 o_msg_ready) else $error("bad accessory reply");
	ident_end_a: assert property (take && in_id && idx == loop_responder_pkg::ID_LAST
		|=> o_reply.data == loop_responder_pkg::CHAR_LF && $past(o_reply.data) == loop_responder_pkg::CHAR_CR)
		else $error("ident not ended by CR LF");
	eot_end_a: assert property (take && drain_eot |=> o_reply.eot && o_msg_ready) else $error("no end of transmission");
	status_first_a: assert property (take && in_stat && idx == 4'h0
		|=> o_reply.data == $past(sys_status)) else $error("status byte one wrong");
	local_keep_a: assert property (is_gtl |=> !o_remote && o_remote_enable == $past(o_remote_enable))
		else $error("go local mishandled");
	remote_dis_a: assert property (is_rdis |=> !o_remote_enable && !o_remote) else $error("remote not disabled");
	remote_data_a: assert property (data_remote |=> !o_ext_valid && o_char == $past(msg_data))
		else $error("remote data forwarded");
	remote_needs_en_a: assert property (o_remote |-> o_remote_enable) else $error("remote without enable");

	drain_cover: cover property (take && drain_eot);
	ident_cover: cover property (take && in_id && idx == loop_responder_pkg::ID_LAST);
	remote_cover: cover property (data_remote);

endmodule : loop_message_responder

`default_nettype wire

// file: loop_controller_model.sv
// Loop controller model: takes reply bytes and logs them in order.
// Assumes the bench reads the log and picks prompt or slow pacing.
`default_nettype none

module loop_controller_model (
	input  wire logic                       i_clock,
	input  wire logic                       i_slow,
	input  wire logic                       i_reply_valid,
	input  wire loop_responder_pkg::reply_s i_reply,
	output logic                            o_reply_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] got [$];
	logic       phase = 1'b0;

	// Slow pacing stalls every other cycle so the held reply is exercised
	assign o_reply_ready = !i_slow || phase;
	always @(posedge i_clock)
	begin
		if (i_reply_valid === 1'b1 && o_reply_ready)
			got.push_back(i_reply);
		phase <= ~phase;
	end
endmodule : loop_controller_model

`default_nettype wire

// file: loop_message_responder_tb.sv
// Self-checking bench: a queue model predicts replies, forwarded bytes and mode levels.
// Assumes the package and FIFO are compiled first; the controller model takes replies.
`default_nettype none

module loop_message_responder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       i_clock = 1'b0;
	logic                       i_arst_n = 1'b0;
	logic                       msg_valid = 1'b0;
	loop_responder_pkg::msg_s   msg = '0;
	logic [4:0]                 own_addr = 5'h05;
	logic                       talker = 1'b0;
	logic                       rx_valid = 1'b0;
	logic [7:0]                 rx_data = 8'h00;
	logic                       slow = 1'b0;
	wire logic                  msg_ready, rx_ready, reply_valid, reply_ready, ext_valid;
	wire logic                  listener, remote, remote_enable;
	wire loop_responder_pkg::reply_s reply;
	wire logic [7:0]            ext_data, ctrl, chr;
	int                         fail_count = 0;
	int                         checks = 0;
	int                         cycles = 0;
	logic                       m_lis = 0, m_rem = 0, m_ren = 0;
	logic [7:0]                 m_ctrl = 8'h00;
	logic [7:0]                 m_chr = loop_responder_pkg::CHAR_RESET;
	logic [31:0]                seed = 32'h800B;
	logic [7:0]                 rxq [$];
	logic [7:0]                 ext_exp [$];
	logic [7:0]                 ext_got [$];
	logic [8:0]                 exp_q [$];

	loop_message_responder dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_msg_valid(msg_valid), .i_msg(msg),
		.o_msg_ready(msg_ready), .i_own_addr(own_addr), .i_talker(talker), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_reply_valid(reply_valid), .o_reply(reply),
		.i_reply_ready(reply_ready), .o_ext_valid(ext_valid), .o_ext_data(ext_data), .o_listener(listener),
		.o_remote(remote), .o_remote_enable(remote_enable), .o_ctrl(ctrl), .o_char(chr));
	loop_controller_model partner (.i_clock(i_clock), .i_slow(slow), .i_reply_valid(reply_valid),
		.i_reply(reply), .o_reply_ready(reply_ready));

	always #4 i_clock = ~i_clock;
	always @(posedge i_clock)
	begin
		if (ext_valid === 1'b1)
			ext_got.push_back(ext_data);
		cycles++;
		if (cycles == 30000)
		begin
			fail_count++;
			conclude();
		end
	end

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd

	function automatic logic [8:0] sys();
		return {1'b0, m_lis, talker, m_rem, m_ren, rxq.size() == 0, rxq.size() == 16, 2'b00};
	endfunction : sys

	task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic push(input logic [7:0] d);
		int n;
		@(posedge i_clock);
		rx_valid <= 1'b1;
		rx_data <= d;
		n = 0;
		do @(posedge i_clock); while (rx_ready !== 1'b1 && ++n < 50);
		rx_valid <= 1'b0;
		if (n < 50)
			rxq.push_back(d);
	endtask : push

	task automatic send(input logic [3:0] k, input logic [7:0] d);
		int n;
		case (k)
			4'h0: if (m_lis && !m_rem) ext_exp.push_back(d); else if (m_lis) m_chr = d;
			4'h1: exp_q.push_back({1'b0, loop_responder_pkg::ACCESSORY_CLASS});
			4'h2: for (int i = 0; i < 8; i++) exp_q.push_back({1'b0, loop_responder_pkg::ID_TEXT[i]});
			4'h3:
			begin
				exp_q.push_back(sys());
				exp_q.push_back({1'b0, m_ctrl});
				exp_q.push_back({1'b0, m_chr});
				exp_q.push_back(9'(rxq.size()));
			end
			4'h4: exp_q.push_back(sys());
			4'h5, 4'h6:
			begin
				m_ctrl = 8'h00;
				m_chr = loop_responder_pkg::CHAR_RESET;
				rxq.delete();
			end
			4'h7: if (m_lis) m_ctrl = d;
			4'h8:
			if (talker)
			begin
				while (rxq.size() > 0) exp_q.push_back({1'b0, rxq.pop_front()});
				exp_q.push_back(9'h100);
			end
			4'h9:
			if (d[4:0] == 5'h1F) m_lis = 0;
			else if (d[4:0] == own_addr)
			begin
				m_lis = 1;
				m_rem = m_rem | m_ren;
			end
			4'hA: m_rem = 0;
			4'hB: {m_ren, m_rem} = {1'b1, m_rem | m_lis};
			4'hC: {m_ren, m_rem} = 2'b00;
			default: ;
		endcase
		@(posedge i_clock);
		msg_valid <= 1'b1;
		msg <= {k, d};
		n = 0;
		do @(posedge i_clock); while (msg_ready !== 1'b1 && ++n < 100);
		msg_valid <= 1'b0;
		n = 0;
		do @(posedge i_clock); while ((msg_ready !== 1'b1 || reply_valid !== 1'b0) && ++n < 400);
		@(posedge i_clock);
		chk("reply count", 9'(exp_q.size()), 9'(partner.got.size()));
		foreach (exp_q[i]) if (i < partner.got.size()) chk("reply byte", exp_q[i], partner.got[i]);
		chk("ext count", 9'(ext_exp.size()), 9'(ext_got.size()));
		foreach (ext_exp[i]) if (i < ext_got.size()) chk("ext byte", {1'b0, ext_exp[i]}, {1'b0, ext_got[i]});
		chk("listener", {8'h00, m_lis}, {8'h00, listener});
		chk("remote", {8'h00, m_rem}, {8'h00, remote});
		chk("remote enable", {8'h00, m_ren}, {8'h00, remote_enable});
		chk("msg ready", 9'h001, {8'h00, msg_ready});
		chk("ctrl", {1'b0, m_ctrl}, {1'b0, ctrl});
		chk("char", {1'b0, m_chr}, {1'b0, chr});
		exp_q.delete();
		partner.got.delete();
		ext_exp.delete();
		ext_got.delete();
	endtask : send

	task automatic conclude();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (4) @(posedge i_clock);
		i_arst_n <= 1'b1;
		send(4'h4, 8'h00);
		send(4'h1, 8'h00);
		send(4'h2, 8'h00);
		$display("test identity done");
		send(4'h7, rnd());
		send(4'h9, 8'h06);
		send(4'h9, 8'h05);
		send(4'h7, rnd());
		send(4'h0, rnd());
		send(4'hB, 8'h00);
		send(4'h3, 8'h00);
		send(4'h0, rnd());
		send(4'hA, 8'h00);
		send(4'h0, rnd());
		send(4'h9, 8'h1F);
		send(4'h9, 8'h05);
		send(4'hC, 8'h00);
		send(4'h9, 8'h1F);
		send(4'h9, 8'h05);
		send(4'h6, 8'h00);
		$display("test modes done");
		slow <= 1'b1;
		for (int i = 0; i < 17; i++) push(rnd());
		chk("rx ready when full", 9'h000, {8'h00, rx_ready});
		send(4'h3, 8'h00);
		send(4'h8, 8'h00);
		talker <= 1'b1;
		// The model reads the talker level at once, so let it settle first
		@(posedge i_clock);
		send(4'h8, 8'h00);
		send(4'h8, 8'h00);
		talker <= 1'b0;
		slow <= 1'b0;
		$display("test talk done");
		for (int i = 0; i < 3; i++) push(rnd());
		send(4'h7, rnd());
		send(4'h6, 8'h00);
		send(4'h3, 8'h00);
		for (int i = 0; i < 2; i++) push(rnd());
		send(4'h7, rnd());
		send(4'h5, 8'h00);
		send(4'h3, 8'h00);
		send(4'h9, 8'h1F);
		send(4'h0, rnd());
		$display("test clears done");
		conclude();
	end
endmodule : loop_message_responder_tb

`default_nettype wire
